// [verification/scatr_link_properties.sv]
// Concurrent checks on the card-terminal link
`timescale 1ns/1ps
module scatr_link_properties #(
	parameter logic [4:0] CARD_CLS = 5'h06,
	parameter logic DI64 = 1'b0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pwr,
	input wire logic rst_n,
	input wire logic [4:0] vcc_class,
	input wire logic io_valid,
	input wire logic [7:0] io_data,
	input wire logic pps_valid,
	input wire logic [7:0] pps_fidi,
	input wire logic pps_ack,
	input wire logic pps_nak
);
	logic [3:0] idx;
	logic [4:0] low;
	logic gap_free;
	logic base_pair;

	// ----------------------------------------
	// Byte position within the answer
	// ----------------------------------------
	// Saturates so user bytes never alias an answer position
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx <= 4'h0;
		end else if (!rst_n || !pwr) begin
			idx <= 4'h0;
		end else if (io_valid && idx != 4'hf) begin
			idx <= idx + 4'h1;
		end
	end
	// Adding the lowest set bit clears a run only when it has no gap
	assign low = io_data[4:0] & (~io_data[4:0] + 5'h01);
	assign gap_free = (io_data[4:0] != 5'h00) &&
		(((io_data[4:0] + low) & io_data[4:0]) == 5'h00);
	assign base_pair = (pps_fidi inside {8'h11, 8'h94, 8'h95});

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	quiet_reset_a: assert property (!rst_n && !$past(rst_n) |-> !io_valid)
		else $error("card sent while held in reset");
	atr_start_a: assert property ($rose(rst_n) && pwr &&
		|(vcc_class & CARD_CLS) |-> ##[1:3] io_valid)
		else $error("answer did not start after reset release");
	ts_first_a: assert property (io_valid && idx == 4'h0 |->
		io_data == scatr_pkg::TS_DIRECT) else $error("first byte wrong");
	atr_burst_a: assert property (io_valid && idx < 4'he |=> io_valid)
		else $error("answer bytes not back to back");
	ta1_pair_a: assert property (io_valid && idx == 4'h2 |->
		io_data inside {8'h11, 8'h94, 8'h95} || (DI64 && io_data == 8'h97))
		else $error("speed byte holds a bad pair");
	global_td_a: assert property (io_valid && idx == 4'h4 |->
		io_data[3:0] == 4'hf && io_data[5:4] == 2'h3)
		else $error("global group not announced");
	class_run_a: assert property (io_valid && idx == 4'h5 |-> gap_free)
		else $error("class bits not a contiguous run");
	tb15_code_a: assert property (io_valid && idx == 4'h6 |->
		io_data == 8'h00 || (io_data & 8'hbe) == 8'hbe)
		else $error("reserved feature byte value");
	hist_cat_a: assert property (io_valid && idx == 4'h7 |-> io_data == 8'h80)
		else $error("category byte wrong");
	cds_tag_a: assert property (io_valid && idx == 4'h8 |-> io_data == 8'h31)
		else $error("first object tag wrong");
	cap_tag_a: assert property (io_valid && idx == 4'ha |-> io_data == 8'h73)
		else $error("second object tag wrong");
	pps_pair_a: assert property (pps_valid |-> base_pair ||
		(DI64 && pps_fidi == 8'h97)) else $error("unsupported pair asked");
	pps_ack_a: assert property (pps_valid && base_pair |=>
		pps_ack && !pps_nak) else $error("mandatory pair not accepted");
	pps_answer_a: assert property (pps_ack || pps_nak |->
		$past(pps_valid)) else $error("answer without request");
	class_onehot_a: assert property (pwr |-> $onehot(vcc_class))
		else $error("applied class not one-hot");
endmodule : scatr_link_properties

// [verification/tb_smart_card_atr_content.sv]
// Self-checking bench for the card and terminal ends
`timescale 1ns/1ps
module tb_smart_card_atr_content;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic tx_valid, tx_ready, atr_done, class_bad, saw_bad;
	logic want_tx, tx_sent;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd, st;
	logic [7:0] tx_data;
	logic [3:0] fi_cur, di_cur;
	logic [6:0] di_val;
	logic [7:0] atr_exp [0:14];
	logic [7:0] seen [$];
	int fails, tests_run, i, n;

	scatr_link_if lnk_if ();
	scatr_card #(.CLASS_SUP(5'h06), .TA1_FI(scatr_pkg::FI_512),
		.TA1_DI(scatr_pkg::DI_16)) scatr_card_inst (.hclk(hclk),
		.hresetn(hresetn), .lnk(lnk_if), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .atr_done(atr_done),
		.class_bad(class_bad), .fi_cur(fi_cur), .di_cur(di_cur),
		.di_val(di_val));
	// Short answer wait keeps the class climb quick
	scatr_term #(.TERM_CLS(5'h07), .ATR_WAIT(40)) scatr_term_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .lnk(lnk_if));
	scatr_link_properties #(.CARD_CLS(5'h06), .DI64(1'b0))
		scatr_link_properties_inst (.hclk(hclk), .hresetn(hresetn),
		.pwr(lnk_if.pwr), .rst_n(lnk_if.rst_n), .vcc_class(lnk_if.vcc_class),
		.io_valid(lnk_if.io_valid), .io_data(lnk_if.io_data),
		.pps_valid(lnk_if.pps_valid), .pps_fidi(lnk_if.pps_fidi),
		.pps_ack(lnk_if.pps_ack), .pps_nak(lnk_if.pps_nak));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// ----------------------------------------
	// Monitors
	// ----------------------------------------
	always @(posedge hclk) begin
		if (lnk_if.io_valid === 1'b1) seen.push_back(lnk_if.io_data);
		// Sole driver of the offer and the mute flag
		if (!hresetn) begin
			saw_bad <= 1'b0;
			tx_valid <= 1'b0;
			tx_sent <= 1'b0;
		end else begin
			if (class_bad === 1'b1) saw_bad <= 1'b1;
			if (tx_valid && tx_ready === 1'b1) begin
				tx_valid <= 1'b0;
				tx_sent <= 1'b1;
			end else begin
				tx_valid <= want_tx && !tx_sent;
			end
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task close_out;
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task fail_now(input string m);
		fails++;
		$display("unexpected at %0t: %s", $time, m);
		close_out();
	endtask : fail_now

	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	task wait_rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			k = k + 1;
			if (k > 50) fail_now("bus wait ran out");
			@(posedge hclk);
		end
	endtask : wait_rdy

	// Called at a rising edge; address phase, then data phase
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		r = hrdata;
	endtask : xfer

	// Offered byte waits until the old session is torn down
	task run(input logic offer);
		int k;
		k = 0;
		xfer(1'b1, scatr_pkg::A_CTRL, 32'h1, rd);
		seen.delete();
		if (offer) begin
			repeat (4) @(posedge hclk);
			want_tx <= 1'b1;
		end
		do begin
			xfer(1'b0, scatr_pkg::A_STAT, 32'h0, st);
			k = k + 1;
		end while (st[7:5] < 3'h6 && k < 600);
		if (k >= 600) fail_now("session never completed");
	endtask : run

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		want_tx = 1'b0;
		tx_data = 8'h5a;
		fails = 0;
		tests_run = 0;
		atr_exp = '{scatr_pkg::TS_DIRECT, {4'h9, scatr_pkg::HIST_LEN}, 8'h95,
			8'h80, 8'h3f, 8'h46, 8'h00, 8'h80, 8'h31, 8'ha0, 8'h73, 8'h00,
			8'h00, 8'h00, 8'h00};
		for (i = 1; i < 14; i++) atr_exp[14] = atr_exp[14] ^ atr_exp[i];
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, scatr_pkg::A_STAT, 32'h0, rd);
		check({26'h0, hresp, rd[11:10], rd[7:5]}, 32'h0);
		xfer(1'b1, 8'h10, 32'hffffffff, rd);
		xfer(1'b0, 8'h10, 32'h0, rd);
		check(rd, 32'h0);
		// First session: class A is tried, card stays mute, B follows
		run(1'b0);
		check({22'h0, st[11:10], st[7:0]}, 32'h000001c2);
		check({30'h0, saw_bad, atr_done}, 32'h3);
		check(32'(seen.size()), 32'd15);
		for (i = 0; i < 15; i++) check({24'h0, seen[i]}, {24'h0, atr_exp[i]});
		xfer(1'b0, scatr_pkg::A_INFO, 32'h0, rd);
		check({8'h0, rd[31:8]}, 32'h00004695);
		xfer(1'b0, scatr_pkg::A_SPEED, 32'h0, rd);
		check(rd, 32'h00001095);
		check({17'h0, fi_cur, di_cur, di_val}, {17'h0, 8'h95, 7'h10});
		// Restart with a user byte already waiting: answer must go first
		run(1'b1);
		check({22'h0, st[11:10], st[7:0]}, 32'h000001c2);
		n = 0;
		while (seen.size() < 16 && n < 100) begin
			@(posedge hclk);
			n = n + 1;
		end
		if (n >= 100) fail_now("user byte never sent");
		for (i = 0; i < 15; i++) check({24'h0, seen[i]}, {24'h0, atr_exp[i]});
		check({24'h0, seen[15]}, 32'h0000005a);
		close_out();
	end
endmodule : tb_smart_card_atr_content

// [verilog/scatr_card.sv]
// Card end: builds and sends the answer-to-reset, then serves the link
`timescale 1ns/1ps

// ----------------------------------------
// Card end
// ----------------------------------------

// Behaviour
// - ATR goes out first after every reset
// - One class bit per supported supply class
// - Supported classes must be neighbours
// - Terminal steps over foreign and historical bytes
// - Global protocol 15 group always present
// - First historical byte is 80 category
// - Objects 31 then 73 lead historical bytes
// - Support 372/1, 512/8 and 512/16
// - Factors advertised and read in TA1
// - Divisor code 0111 means 64, FI 1001
// - Terminal negotiates any non-default pair; code asks only when TA1 FI is 1001 with DI 8 or more, else keeps 372/1
// - Global bytes follow TD naming 15
// - First global TB: none or low impedance
// - Terminal starts lowest class, climbs on silence
// - Three corrupt ATRs before rejecting card
module scatr_card #(
	parameter logic [4:0] CLASS_SUP = 5'h06,
	parameter logic [3:0] TA1_FI = scatr_pkg::FI_512,
	parameter logic [3:0] TA1_DI = scatr_pkg::DI_16,
	parameter logic DI64_SUP = 1'b0,
	parameter logic [1:0] CLK_STOP = 2'h1,
	parameter logic [7:0] TB_FEAT = scatr_pkg::TB_NONE,
	parameter logic [7:0] CDS_DATA = 8'ha0,
	parameter logic [23:0] CAP_DATA = 24'h000000
) (
	input wire logic hclk,
	input wire logic hresetn,
	scatr_link_if.card lnk,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic atr_done,
	output logic class_bad,
	output logic [3:0] fi_cur,
	output logic [3:0] di_cur,
	output logic [6:0] di_val
);

	typedef enum logic [1:0] {
		C_OFF = 2'b00,
		C_ATR = 2'b01,
		C_RUN = 2'b10,
		C_MUTE = 2'b11
	} scatr_cst_e;

	scatr_cst_e st_reg;
	logic [3:0] idx_reg;
	logic [7:0] chk_reg;
	logic live;
	logic take;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	function automatic logic contig(input logic [4:0] c);
		logic [4:0] low;
		low = c & (~c + 5'h01);
		contig = (c != 5'h00) && (((c + low) & c) == 5'h00);
	endfunction : contig

	generate
		if (!contig(CLASS_SUP)) begin : g_cls_chk
			$error("Supply classes must be a gapless run");
		end
		if (TA1_DI == scatr_pkg::DI_64 &&
			(TA1_FI != scatr_pkg::FI_512 || !DI64_SUP)) begin : g_di_chk
			$error("Divisor 64 needs FI 1001 and support");
		end
		if (TB_FEAT != scatr_pkg::TB_NONE &&
			(TB_FEAT & scatr_pkg::TB_LOWZ) != scatr_pkg::TB_LOWZ)
		begin : g_tb_chk
			$error("Global TB value is reserved");
		end
	endgenerate

	// ----------------------------------------
	// Answer-to-reset image
	// ----------------------------------------
	// Fixed layout keeps the check byte a simple running parity
	function automatic logic [7:0] atr_byte(input logic [3:0] i);
		case (i)
			4'h0: atr_byte = scatr_pkg::TS_DIRECT;
			4'h1: atr_byte = scatr_pkg::T0_TA_TD |
				{4'h0, scatr_pkg::HIST_LEN};
			4'h2: atr_byte = {TA1_FI, TA1_DI};
			4'h3: atr_byte = scatr_pkg::TD1_T0;
			4'h4: atr_byte = scatr_pkg::TD2_T15;
			4'h5: atr_byte = {CLK_STOP, 1'b0, CLASS_SUP};
			4'h6: atr_byte = TB_FEAT;
			4'h7: atr_byte = scatr_pkg::CAT_COMPACT;
			4'h8: atr_byte = scatr_pkg::TAG_CDS;
			4'h9: atr_byte = CDS_DATA;
			4'ha: atr_byte = scatr_pkg::TAG_CAP;
			4'hb: atr_byte = CAP_DATA[23:16];
			4'hc: atr_byte = CAP_DATA[15:8];
			4'hd: atr_byte = CAP_DATA[7:0];
			default: atr_byte = 8'h00;
		endcase
	endfunction : atr_byte

	assign live = lnk.pwr && lnk.rst_n;
	assign take = (st_reg == C_RUN) && tx_valid && tx_ready;

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	// Warm and cold reset both restart the same image
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= C_OFF;
		end else if (!live) begin
			st_reg <= C_OFF;
		end else begin
			case (st_reg)
				C_OFF: begin
					// Silent on an unsupported class so terminal climbs
					if ((lnk.vcc_class & CLASS_SUP) != 5'h00) begin
						st_reg <= C_ATR;
					end else begin
						st_reg <= C_MUTE;
					end
				end
				C_ATR: begin
					if (idx_reg == scatr_pkg::ATR_LAST) begin
						st_reg <= C_RUN;
					end
				end
				default: begin
					st_reg <= st_reg;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_reg <= 4'h0;
		end else if (st_reg == C_ATR && live) begin
			idx_reg <= idx_reg + 4'h1;
		end else begin
			idx_reg <= 4'h0;
		end
	end

	// Check byte: parity of everything after the initial byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chk_reg <= 8'h00;
		end else if (st_reg == C_ATR && idx_reg != 4'h0) begin
			chk_reg <= chk_reg ^ atr_byte(idx_reg);
		end else if (st_reg != C_ATR) begin
			chk_reg <= 8'h00;
		end
	end

	// ----------------------------------------
	// Byte output
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lnk.io_valid <= 1'b0;
			lnk.io_data <= 8'h00;
		end else if (live && st_reg == C_ATR) begin
			lnk.io_valid <= 1'b1;
			if (idx_reg == scatr_pkg::ATR_LAST) begin
				lnk.io_data <= chk_reg;
			end else begin
				lnk.io_data <= atr_byte(idx_reg);
			end
		end else begin
			lnk.io_valid <= live && take;
			lnk.io_data <= take ? tx_data : 8'h00;
		end
	end

	// User bytes wait until the whole ATR has gone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_ready <= 1'b0;
			atr_done <= 1'b0;
			class_bad <= 1'b0;
		end else begin
			tx_ready <= live && st_reg == C_RUN;
			atr_done <= live && st_reg == C_RUN;
			class_bad <= st_reg == C_MUTE;
		end
	end

	// ----------------------------------------
	// Speed selection
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fi_cur <= scatr_pkg::FI_372;
			di_cur <= scatr_pkg::DI_1;
			lnk.pps_ack <= 1'b0;
			lnk.pps_nak <= 1'b0;
		end else if (!live) begin
			fi_cur <= scatr_pkg::FI_372;
			di_cur <= scatr_pkg::DI_1;
			lnk.pps_ack <= 1'b0;
			lnk.pps_nak <= 1'b0;
		end else if (st_reg == C_RUN && lnk.pps_valid) begin
			if (scatr_pkg::pair_ok(lnk.pps_fidi[7:4],
				lnk.pps_fidi[3:0], DI64_SUP)) begin
				fi_cur <= lnk.pps_fidi[7:4];
				di_cur <= lnk.pps_fidi[3:0];
				lnk.pps_ack <= 1'b1;
				lnk.pps_nak <= 1'b0;
			end else begin
				lnk.pps_ack <= 1'b0;
				lnk.pps_nak <= 1'b1;
			end
		end else begin
			lnk.pps_ack <= 1'b0;
			lnk.pps_nak <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			di_val <= 7'h01;
		end else begin
			di_val <= scatr_pkg::di_div(di_cur);
		end
	end

endmodule : scatr_card

// [verilog/scatr_link_if.sv]
// Link between card and terminal controller
`timescale 1ns/1ps
interface scatr_link_if;
	logic pwr;
	logic rst_n;
	logic [4:0] vcc_class;
	logic io_valid;
	logic [7:0] io_data;
	logic pps_valid;
	logic [7:0] pps_fidi;
	logic pps_ack;
	logic pps_nak;
	modport card (
		input pwr, rst_n, vcc_class, pps_valid, pps_fidi,
		output io_valid, io_data, pps_ack, pps_nak
	);
	modport term (
		output pwr, rst_n, vcc_class, pps_valid, pps_fidi,
		input io_valid, io_data, pps_ack, pps_nak
	);
endinterface : scatr_link_if

// [verilog/scatr_pkg.sv]
// Shared constants and decoders for the answer-to-reset link
package scatr_pkg;

	// ----------------------------------------
	// Answer-to-reset bytes
	// ----------------------------------------
	localparam logic [7:0] TS_DIRECT = 8'h3b;
	localparam logic [7:0] TS_INVERSE = 8'h3f;
	localparam logic [7:0] T0_TA_TD = 8'h90;
	localparam logic [7:0] TD1_T0 = 8'h80;
	localparam logic [7:0] TD2_T15 = 8'h3f;
	localparam logic [3:0] T_GLOBAL = 4'hf;
	localparam logic [7:0] CAT_COMPACT = 8'h80;
	localparam logic [7:0] TAG_CDS = 8'h31;
	localparam logic [7:0] TAG_CAP = 8'h73;
	localparam logic [7:0] TB_NONE = 8'h00;
	localparam logic [7:0] TB_LOWZ = 8'hbe;
	localparam logic [3:0] HIST_LEN = 4'h7;
	localparam logic [3:0] ATR_LAST = 4'he;
	localparam logic [4:0] CLASS_A = 5'h01;

	// ----------------------------------------
	// Speed factor codes
	// ----------------------------------------
	localparam logic [3:0] FI_372 = 4'h1;
	localparam logic [3:0] FI_512 = 4'h9;
	localparam logic [3:0] DI_1 = 4'h1;
	localparam logic [3:0] DI_8 = 4'h4;
	localparam logic [3:0] DI_16 = 4'h5;
	localparam logic [3:0] DI_64 = 4'h7;

	// ----------------------------------------
	// Controller registers and timing
	// ----------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_INFO = 8'h08;
	localparam logic [7:0] A_SPEED = 8'h0c;
	localparam logic [7:0] RST_HOLD = 8'h28;
	localparam logic [1:0] MAX_TRIES = 2'h3;

	function automatic logic pair_ok(input logic [3:0] fi,
		input logic [3:0] di, input logic di64);
		pair_ok = (fi == FI_372 && di == DI_1) ||
			(fi == FI_512 && (di == DI_8 || di == DI_16 ||
			(di == DI_64 && di64)));
	endfunction : pair_ok

	function automatic logic [6:0] di_div(input logic [3:0] di);
		case (di)
			DI_1: di_div = 7'h01;
			DI_8: di_div = 7'h08;
			DI_16: di_div = 7'h10;
			DI_64: di_div = 7'h40;
			default: di_div = 7'h00;
		endcase
	endfunction : di_div

endpackage : scatr_pkg

// [verilog/scatr_term.sv]
// Terminal end: activates the card, parses its ATR, picks the speed
`timescale 1ns/1ps
module scatr_term #(
	parameter logic [4:0] TERM_CLS = 5'h07,
	parameter logic DI64_SUP = 1'b0,
	parameter int ATR_WAIT = 400
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	scatr_link_if.term lnk
);

	typedef enum logic [2:0] {
		T_IDLE = 3'b000, T_OFF = 3'b001, T_RST = 3'b010, T_WAIT = 3'b011,
		T_PPS = 3'b100, T_PPSW = 3'b101, T_DONE = 3'b110, T_FAIL = 3'b111
	} scatr_tst_e;
	typedef enum logic [2:0] {
		P_TS = 3'b000, P_T0 = 3'b001, P_IF = 3'b010, P_HIST = 3'b011,
		P_TCK = 3'b100, P_END = 3'b101
	} scatr_pst_e;

	generate
		if (ATR_WAIT < 2 || ATR_WAIT > 65535) begin : g_wait_chk
			$error("ATR_WAIT out of range");
		end
	endgenerate

	scatr_tst_e st_reg;
	scatr_pst_e ps_reg;
	logic [15:0] cnt_reg;
	logic [1:0] try_reg;
	logic [3:0] ym_reg, hl_reg, hp_reg, tg_reg;
	logic [1:0] tn_reg;
	logic [7:0] xr_reg, ta1_reg, ta15_reg, tb15_reg;
	logic t15_reg, got15_reg, tck_reg, ta15v_reg, tb15v_reg, err_reg;
	logic seen_reg, start, wr_reg;
	logic [7:0] wa_reg;
	logic [3:0] ym_next, fi_sel, di_sel;
	logic tck_next, bad, ok_card;
	logic [4:0] ccls, clow, cnext;
	logic [7:0] b;

	assign b = lnk.io_data;

	// ----------------------------------------
	// Parser
	// ----------------------------------------
	always_comb begin
		ym_next = ym_reg & (ym_reg - 4'h1);
		tck_next = tck_reg;
		if (ym_reg[2:0] == 3'h0) begin
			ym_next = b[7:4];
			tck_next = tck_reg | (b[3:0] != 4'h0);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ps_reg <= P_TS; ym_reg <= 4'h0; hl_reg <= 4'h0;
			hp_reg <= 4'h0; tg_reg <= 4'h1; tn_reg <= 2'h0;
			xr_reg <= 8'h00; t15_reg <= 1'b0; got15_reg <= 1'b0;
			tck_reg <= 1'b0; err_reg <= 1'b0; seen_reg <= 1'b0;
			ta1_reg <= 8'h11; ta15_reg <= 8'h00; tb15_reg <= 8'h00;
			ta15v_reg <= 1'b0; tb15v_reg <= 1'b0;
		end else if (st_reg == T_RST) begin
			ps_reg <= P_TS; tg_reg <= 4'h1; tn_reg <= 2'h0; hp_reg <= 4'h0;
			t15_reg <= 1'b0; got15_reg <= 1'b0; tck_reg <= 1'b0;
			err_reg <= 1'b0; seen_reg <= 1'b0; ta1_reg <= 8'h11;
			ta15v_reg <= 1'b0; tb15v_reg <= 1'b0;
		end else if (lnk.io_valid && st_reg == T_WAIT) begin
			seen_reg <= 1'b1;
			case (ps_reg)
				P_TS: begin
					err_reg <= b != scatr_pkg::TS_DIRECT &&
						b != scatr_pkg::TS_INVERSE;
					ps_reg <= P_T0;
				end
				P_T0: begin
					xr_reg <= b; ym_reg <= b[7:4]; hl_reg <= b[3:0];
					ps_reg <= b[7:4] != 4'h0 ? P_IF :
						(b[3:0] != 4'h0 ? P_HIST : P_END);
				end
				P_IF: begin
					xr_reg <= xr_reg ^ b; ym_reg <= ym_next;
					tck_reg <= tck_next;
					if (ym_reg[0] && !t15_reg) begin
						ta1_reg <= b;
					end
					if (ym_reg[0] && t15_reg && !ta15v_reg) begin
						ta15_reg <= b; ta15v_reg <= 1'b1;
					end
					if (ym_reg[1:0] == 2'b10 && t15_reg && !tb15v_reg) begin
						tb15_reg <= b; tb15v_reg <= 1'b1;
					end
					if (ym_reg[2:0] == 3'h0) begin
						t15_reg <= b[3:0] == scatr_pkg::T_GLOBAL;
						got15_reg <= got15_reg | (b[3:0] == scatr_pkg::T_GLOBAL);
					end
					// Foreign protocol groups are simply walked past
					if (ym_next == 4'h0) begin
						ps_reg <= hl_reg != 4'h0 ? P_HIST :
							(tck_next ? P_TCK : P_END);
					end
				end
				P_HIST: begin
					xr_reg <= xr_reg ^ b; hp_reg <= hp_reg + 4'h1;
					hl_reg <= hl_reg - 4'h1;
					if (hp_reg == 4'h0 && b != scatr_pkg::CAT_COMPACT) begin
						err_reg <= 1'b1;
					end
					if (hp_reg == tg_reg && tn_reg != 2'h2) begin
						tg_reg <= hp_reg + 4'h1 + b[3:0];
						tn_reg <= tn_reg + 2'h1;
						if (b != (tn_reg == 2'h0 ? scatr_pkg::TAG_CDS :
							scatr_pkg::TAG_CAP)) begin
							err_reg <= 1'b1;
						end
					end
					if (hl_reg == 4'h1) begin
						ps_reg <= tck_reg ? P_TCK : P_END;
					end
				end
				P_TCK: begin
					err_reg <= err_reg | ((xr_reg ^ b) != 8'h00);
					ps_reg <= P_END;
				end
				default: ps_reg <= P_END;
			endcase
		end
	end

	// ----------------------------------------
	// Activation sequence
	// ----------------------------------------
	assign bad = err_reg || !got15_reg || tn_reg != 2'h2 ||
		(tb15v_reg && tb15_reg != scatr_pkg::TB_NONE &&
		(tb15_reg & scatr_pkg::TB_LOWZ) != scatr_pkg::TB_LOWZ);
	assign ccls = (ta15v_reg ? ta15_reg[4:0] : scatr_pkg::CLASS_A)
		& TERM_CLS;
	assign clow = ccls & (~ccls + 5'h01);
	assign cnext = {lnk.vcc_class[3:0], 1'b0};
	assign ok_card = (ccls & lnk.vcc_class) != 5'h00;

	always_comb begin
		fi_sel = scatr_pkg::FI_372;
		di_sel = scatr_pkg::DI_1;
		if (ta1_reg[7:4] == scatr_pkg::FI_512) begin
			fi_sel = scatr_pkg::FI_512;
			if (ta1_reg[3:0] == scatr_pkg::DI_64 && DI64_SUP) begin
				di_sel = scatr_pkg::DI_64;
			end else if (ta1_reg[3:0] >= scatr_pkg::DI_16) begin
				di_sel = scatr_pkg::DI_16;
			end else if (ta1_reg[3:0] == scatr_pkg::DI_8) begin
				di_sel = scatr_pkg::DI_8;
			end else begin
				fi_sel = scatr_pkg::FI_372;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= T_IDLE; cnt_reg <= 16'h0000; try_reg <= 2'h0;
			lnk.pwr <= 1'b0; lnk.rst_n <= 1'b0;
			lnk.vcc_class <= scatr_pkg::CLASS_A;
			lnk.pps_valid <= 1'b0; lnk.pps_fidi <= 8'h11;
		end else begin
			lnk.pps_valid <= 1'b0;
			cnt_reg <= cnt_reg + 16'h0001;
			case (st_reg)
				T_IDLE, T_DONE, T_FAIL: begin
					if (start) begin
						st_reg <= T_OFF; try_reg <= 2'h0; cnt_reg <= 16'h0000;
						lnk.vcc_class <= TERM_CLS & (~TERM_CLS + 5'h01);
						lnk.pps_fidi <= 8'h11;
					end
				end
				T_OFF: begin
					lnk.pwr <= 1'b0; lnk.rst_n <= 1'b0;
					if (cnt_reg[7:0] == scatr_pkg::RST_HOLD) begin
						st_reg <= T_RST; cnt_reg <= 16'h0000;
					end
				end
				T_RST: begin
					lnk.pwr <= 1'b1;
					if (cnt_reg[7:0] == scatr_pkg::RST_HOLD) begin
						lnk.rst_n <= 1'b1; st_reg <= T_WAIT; cnt_reg <= 16'h0000;
					end
				end
				T_WAIT: begin
					if (ps_reg == P_END) begin
						cnt_reg <= 16'h0000;
						if (bad) begin
							try_reg <= try_reg + 2'h1;
							st_reg <= try_reg == scatr_pkg::MAX_TRIES - 2'h1 ?
								T_FAIL : T_OFF;
						end else if (!ok_card) begin
							try_reg <= 2'h0;
							// Applied class not common: switch to the lowest common class and cycle power, or fail if none
							if (clow != 5'h00) begin
								lnk.vcc_class <= clow;
							end
							st_reg <= clow != 5'h00 ? T_OFF : T_FAIL;
						end else if (fi_sel != scatr_pkg::FI_372) begin
							lnk.pps_fidi <= {fi_sel, di_sel};
							st_reg <= T_PPS;
						end else begin
							st_reg <= T_DONE;
						end
					end else if (cnt_reg == 16'(ATR_WAIT)) begin
						cnt_reg <= 16'h0000;
						if (seen_reg) begin
							try_reg <= try_reg + 2'h1;
							st_reg <= try_reg == scatr_pkg::MAX_TRIES - 2'h1 ?
								T_FAIL : T_OFF;
						end else if ((cnext & TERM_CLS) != 5'h00) begin
							lnk.vcc_class <= cnext; st_reg <= T_OFF;
						end else begin
							st_reg <= T_FAIL;
						end
					end
				end
				T_PPS: begin
					lnk.pps_valid <= 1'b1; st_reg <= T_PPSW;
				end
				T_PPSW: begin
					if (lnk.pps_nak) begin
						lnk.pps_fidi <= 8'h11;
					end
					if (lnk.pps_ack || lnk.pps_nak) begin
						st_reg <= T_DONE;
					end
				end
				default: st_reg <= T_IDLE;
			endcase
			if (st_reg == T_FAIL || st_reg == T_IDLE) begin
				lnk.pwr <= 1'b0; lnk.rst_n <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	// Zero wait states: read data is loaded in the address phase
	assign start = wr_reg && wa_reg == scatr_pkg::A_CTRL && hwdata[0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= 1'b0; wa_reg <= 8'h00; hrdata <= 32'h00000000;
			hreadyout <= 1'b1; hresp <= 1'b0;
		end else if (hsel && hready && htrans[1]) begin
			wr_reg <= hwrite; wa_reg <= haddr[7:0];
			if (hwrite) begin
				hrdata <= 32'h00000000;
			end else if (haddr[7:0] == scatr_pkg::A_STAT) begin
				hrdata <= {20'h00000, st_reg == T_FAIL, st_reg == T_DONE,
					try_reg, st_reg, lnk.vcc_class};
			end else if (haddr[7:0] == scatr_pkg::A_INFO) begin
				hrdata <= {tb15_reg, ta15_reg, ta1_reg, 4'h0, hl_reg};
			end else if (haddr[7:0] == scatr_pkg::A_SPEED) begin
				hrdata <= {17'h00000, scatr_pkg::di_div(lnk.pps_fidi[3:0]),
					lnk.pps_fidi};
			end else begin
				hrdata <= 32'h00000000;
			end
		end else begin
			wr_reg <= 1'b0;
		end
	end

endmodule : scatr_term
